// >>> pilc_ctrl.v
// Parallel I/O line controller: register file, pin muxing and change interrupt.
`timescale 1ns/100ps
`include "pilc_defines.vh"
module pilc_ctrl #(
    parameter [31:0] BASE_ADDR = `PILC_SECOND_INSTANCE_BASE,
    parameter [31:0] OWNER_RESET = `PILC_OWNER_RST_SECOND,
    parameter [31:0] IMPL_MASK = `PILC_IMPL_SECOND,
    parameter [31:0] OFF_LEVEL = `PILC_OFF_LEVEL_DEFAULT
) (
    // Clock and reset
    input wire clock,
    input wire nrst,
    // Register port
    input wire [31:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    // External pins
    input wire [31:0] pin_in,
    output reg [31:0] pin_out_q,
    output reg [31:0] pin_oe_q,
    // On-chip peripheral functions
    input wire [31:0] periph_out,
    input wire [31:0] periph_oe,
    output reg [31:0] periph_in_q,
    // Interrupt
    output reg irq_q
);

    // ============================================================
    // Helpers

    // Applies a set/clear register write to one setting vector.
    function [31:0] set_clr;
        input [31:0] cur;
        input set_hit;
        input clr_hit;
        input [31:0] data;
        begin
            set_clr = cur;
            if (set_hit) begin
                set_clr = cur | (data & IMPL_MASK);
            end else if (clr_hit) begin
                set_clr = cur & ~(data & IMPL_MASK);
            end
        end
    endfunction

    // ============================================================
    // Address decode

    wire sel;
    wire [`PILC_OFF_BITS-1:0] off;
    wire wr_hit;
    wire rd_hit;

    // Every instance sees the same offsets relative to its own base.
    assign sel = (reg_addr[31:`PILC_OFF_BITS] == BASE_ADDR[31:`PILC_OFF_BITS]);
    assign off = reg_addr[`PILC_OFF_BITS-1:0];
    assign wr_hit = reg_wr & sel;
    assign rd_hit = reg_rd & sel;

    // ============================================================
    // Setting registers

    // Each setting is a plain vector of flip-flops with one bit per line.
    // Software never writes the vector itself: a set offset ORs ones in and
    // a clear offset ANDs them out. Two masters sharing a setting can then
    // change their own lines without a read-modify-write race.
    // Bits above the implemented lines are masked on every write, so they
    // stay at zero forever and the read path needs no extra care for them.
    // The ownership vector is the only one with a non-zero reset value; it
    // comes from a parameter so that one body serves both instances.
    reg [31:0] owner_q;
    reg [31:0] drive_en_q;
    reg [31:0] filter_en_q;
    reg [31:0] out_level_q;
    reg [31:0] irq_mask_q;
    reg [31:0] open_drain_q;
    reg [31:0] irq_status_q;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            owner_q <= OWNER_RESET;
            drive_en_q <= `PILC_CFG_RST;
            filter_en_q <= `PILC_CFG_RST;
            out_level_q <= `PILC_CFG_RST;
            irq_mask_q <= `PILC_CFG_RST;
            open_drain_q <= `PILC_CFG_RST;
        end else begin
            // Writes to offsets outside these pairs fall through untouched.
            owner_q <= set_clr(owner_q,
                wr_hit && off == `PILC_OFF_LINE_OWNER_SET,
                wr_hit && off == `PILC_OFF_LINE_OWNER_CLEAR,
                reg_wdata);
            drive_en_q <= set_clr(drive_en_q,
                wr_hit && off == `PILC_OFF_DRIVE_ENABLE_SET,
                wr_hit && off == `PILC_OFF_DRIVE_ENABLE_CLEAR,
                reg_wdata);
            filter_en_q <= set_clr(filter_en_q,
                wr_hit && off == `PILC_OFF_GLITCH_FILTER_SET,
                wr_hit && off == `PILC_OFF_GLITCH_FILTER_CLEAR,
                reg_wdata);
            out_level_q <= set_clr(out_level_q,
                wr_hit && off == `PILC_OFF_OUT_LEVEL_SET,
                wr_hit && off == `PILC_OFF_OUT_LEVEL_CLEAR,
                reg_wdata);
            irq_mask_q <= set_clr(irq_mask_q,
                wr_hit && off == `PILC_OFF_CHANGE_IRQ_ENABLE,
                wr_hit && off == `PILC_OFF_CHANGE_IRQ_DISABLE,
                reg_wdata);
            open_drain_q <= set_clr(open_drain_q,
                wr_hit && off == `PILC_OFF_OPEN_DRAIN_SET,
                wr_hit && off == `PILC_OFF_OPEN_DRAIN_CLEAR,
                reg_wdata);
        end
    end

    // ============================================================
    // Pin input path

    reg [31:0] pin_meta_q;
    reg [31:0] pin_sync_q;
    wire [31:0] pin_level;

    // Pins are asynchronous to the clock; only the second stage is read onward.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pin_meta_q <= 32'h00000000;
            pin_sync_q <= 32'h00000000;
        end else begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // The filter applies whether the line is owned by the controller or not.
    pilc_glitch_filter #(
        .WIDTH(32)
    ) u_filter (
        .clock(clock),
        .nrst(nrst),
        .level_in(pin_sync_q),
        .filter_en(filter_en_q),
        .level_q(pin_level)
    );

    // ============================================================
    // Level change detection

    reg [31:0] prev_level_q;
    reg [2:0] prime_cnt_q;
    wire primed;
    wire [31:0] change;
    wire isr_read;

    // The pipeline resets to zero, which is not a pin level; detection waits
    // until real levels have reached both compare points, so reset itself
    // never looks like a change.
    assign primed = (prime_cnt_q == `PILC_PRIME_CYCLES);
    assign change = primed ? ((pin_level ^ prev_level_q) & IMPL_MASK) : 32'h00000000;
    assign isr_read = rd_hit && (off == `PILC_OFF_CHANGE_IRQ_STATUS);

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prev_level_q <= 32'h00000000;
            prime_cnt_q <= 3'h0;
            irq_status_q <= 32'h00000000;
        end else begin
            prev_level_q <= pin_level;
            if (!primed) begin
                prime_cnt_q <= prime_cnt_q + 3'h1;
            end
            // A change in the cycle of the clearing read survives to the next read.
            irq_status_q <= (isr_read ? 32'h00000000 : irq_status_q) | change;
        end
    end

    // ============================================================
    // Pin and peripheral muxing

    wire [31:0] drv_level;
    wire [31:0] drv_en;

    // Ownership selects the source; open drain only ever pulls low.
    // The drive enable and the output data of a peripheral-owned line are
    // kept in their registers but have no effect until the line is owned.
    // Open drain applies under either owner, so a peripheral output can
    // share a wired-AND net with outside drivers as well.
    // A released open-drain line relies on an outside pull-up for its high
    // level; without one the pin floats and the change detector may fire.
    // All pad outputs are registered, which costs one cycle of latency but
    // keeps combinational paths from the register port off the pads.
    assign drv_level = (owner_q & out_level_q) | (~owner_q & periph_out);
    assign drv_en = (owner_q & drive_en_q) | (~owner_q & periph_oe);

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pin_out_q <= 32'h00000000;
            pin_oe_q <= 32'h00000000;
            periph_in_q <= OFF_LEVEL;
            irq_q <= 1'b0;
        end else begin
            pin_out_q <= drv_level & ~open_drain_q & IMPL_MASK;
            pin_oe_q <= drv_en & ~(open_drain_q & drv_level) & IMPL_MASK;
            periph_in_q <= ((owner_q & OFF_LEVEL) | (~owner_q & pin_level)) & IMPL_MASK;
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    // ============================================================
    // Read path

    reg [31:0] rd_mux;

    always @* begin
        case (off)
            `PILC_OFF_LINE_OWNER_STATUS: begin
                rd_mux = owner_q;
            end
            `PILC_OFF_DRIVE_ENABLE_STATUS: begin
                rd_mux = drive_en_q;
            end
            `PILC_OFF_GLITCH_FILTER_STATUS: begin
                rd_mux = filter_en_q;
            end
            `PILC_OFF_OUT_LEVEL_STATUS: begin
                rd_mux = out_level_q;
            end
            `PILC_OFF_PIN_LEVEL_SAMPLE: begin
                rd_mux = pin_level;
            end
            `PILC_OFF_CHANGE_IRQ_MASK: begin
                rd_mux = irq_mask_q;
            end
            `PILC_OFF_CHANGE_IRQ_STATUS: begin
                rd_mux = irq_status_q;
            end
            `PILC_OFF_OPEN_DRAIN_STATUS: begin
                rd_mux = open_drain_q;
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    // Returning zero outside a read answer lets several slaves share one
    // read data bus by a plain OR, with no select logic at the master.
    // Reads of the change status have a side effect, so a read that misses
    // the window must not touch it; the decode above guarantees that.
    // The pin level view is the filtered, synchronised level, so it lags
    // the pins by the synchroniser and filter depth.
    // No read ever stalls; the master may issue strobes back to back.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_q <= 32'h00000000;
        end else if (rd_hit) begin
            reg_rdata_q <= rd_mux & IMPL_MASK;
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end

endmodule // pilc_ctrl

// >>> pilc_ctrl_bench.sv
// Self-checking bench for the parallel I/O line controller, second instance.
`timescale 1ns/100ps
module pilc_ctrl_bench;
    reg clock = 1'b0;
    reg nrst = 1'b0;
    reg [31:0] base = 32'hFFFF0000;
    reg [31:0] reg_addr = 32'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [31:0] ext_level = 32'h12345678;
    reg [31:0] periph_out = 32'h0;
    reg [31:0] periph_oe = 32'h0;
    wire [31:0] reg_rdata_q, pin_in, pin_out_q, pin_oe_q, periph_in_q;
    wire irq_q;
    integer err_count = 0;
    integer checked = 0;
    integer cycles = 0;
    integer i;
    reg [6:0] o;
    pilc_ctrl pilc_ctrl_inst (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_in_q(periph_in_q), .irq_q(irq_q));
    pilc_pin_model pilc_pin_model_inst (.pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q),
        .ext_level(ext_level), .pin_in(pin_in));
    // ====
    // Tasks
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [6:0] a, input [31:0] d);
        begin
            @(posedge clock);
            reg_addr <= base + a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clock);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [6:0] a, input [31:0] exp);
        begin
            @(posedge clock);
            reg_addr <= base + a;
            reg_rd <= 1'b1;
            @(posedge clock);
            reg_rd <= 1'b0;
            #1;
            chk(reg_rdata_q, exp);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", checked, err_count);
            if (err_count == 0 && checked > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    // ====
    // Clock and watchdog
    initial begin
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count = err_count + 1;
            $display("[ERR] %0t run did not finish", $time);
            finish_test;
        end
    end
    // ====
    // Sequence
    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (8) @(posedge clock);
        rd(7'h08, 32'h00FFFFC0);
        rd(7'h3C, 32'h00345678);
        for (i = 0; i < 24; i = i + 1) begin
            o = i * 4;
            if (o != 7'h08 && o != 7'h3C) rd(o, 32'h0);
        end
        base = 32'hFFFEC000;
        wr(7'h04, 32'hFFFFFFFF);
        rd(7'h08, 32'h0);
        base = 32'hFFFF0000;
        rd(7'h08, 32'h00FFFFC0);
        wr(7'h04, 32'h00000040);
        rd(7'h08, 32'h00FFFF80);
        repeat (6) @(posedge clock);
        chk({31'h0, periph_in_q[6]}, 32'h1);
        wr(7'h00, 32'hFF000040);
        rd(7'h08, 32'h00FFFFC0);
        chk(periph_in_q & 32'hFFFFFFC0, 32'h0);
        wr(7'h10, 32'h00000300);
        wr(7'h30, 32'h00000100);
        rd(7'h38, 32'h00000100);
        rd(7'h18, 32'h00000300);
        chk(pin_oe_q, 32'h00000300);
        chk(pin_out_q, 32'h00000100);
        wr(7'h50, 32'h00000200);
        wr(7'h30, 32'h00000200);
        rd(7'h58, 32'h00000200);
        chk(pin_oe_q, 32'h00000100);
        wr(7'h34, 32'h00000300);
        rd(7'h38, 32'h0);
        repeat (10) @(posedge clock);
        rd(7'h3C, 32'h00345478);
        rd(7'h4C, 32'h00000300);
        rd(7'h4C, 32'h0);
        wr(7'h40, 32'h00000400);
        rd(7'h48, 32'h00000400);
        ext_level <= ext_level ^ 32'h00000400;
        repeat (8) @(posedge clock);
        chk({31'h0, irq_q}, 32'h1);
        rd(7'h4C, 32'h00000400);
        repeat (2) @(posedge clock);
        chk({31'h0, irq_q}, 32'h0);
        ext_level <= ext_level ^ 32'h00000400;
        repeat (8) @(posedge clock);
        wr(7'h44, 32'h00000400);
        @(posedge clock);
        #1;
        chk({31'h0, irq_q}, 32'h0);
        rd(7'h48, 32'h0);
        wr(7'h20, 32'h00000800);
        rd(7'h28, 32'h00000800);
        wr(7'h24, 32'h00000800);
        rd(7'h28, 32'h0);
        periph_oe <= 32'h00000003;
        periph_out <= 32'h00000001;
        repeat (3) @(posedge clock);
        #1;
        chk(pin_oe_q, 32'h00000303);
        chk(pin_out_q & 32'h00000003, 32'h00000001);
        finish_test;
    end
endmodule // pilc_ctrl_bench

// >>> pilc_ctrl_props.sv
// Port-level assertions for the parallel I/O line controller.
`timescale 1ns/100ps
module pilc_ctrl_props #(
    parameter [31:0] BASE_ADDR = 32'hFFFF0000,
    parameter [31:0] OWNER_RESET = 32'h00FFFFC0,
    parameter [31:0] IMPL_MASK = 32'h00FFFFFF,
    parameter [31:0] OFF_LEVEL = 32'h00000000
) (
    // Clock, reset and register port
    input wire clock,
    input wire nrst,
    input wire [31:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata_q,
    // Pins, peripheral side and interrupt
    input wire [31:0] pin_in,
    input wire [31:0] pin_out_q,
    input wire [31:0] pin_oe_q,
    input wire [31:0] periph_out,
    input wire [31:0] periph_oe,
    input wire [31:0] periph_in_q,
    input wire irq_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // ====
    // Decode
    wire hit = reg_addr[31:7] == BASE_ADDR[31:7];
    wire [6:0] off = reg_addr[6:0];
    wire wr_hit = reg_wr && hit;
    wire rd_hit = reg_rd && hit;
    wire ro_off = off inside {7'h08, 7'h18, 7'h28, 7'h38, 7'h3C, 7'h48, 7'h4C, 7'h58};
    reg [31:0] mask_q;
    // The mask copy updates on the same edge as the design's mask.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mask_q <= 32'h00000000;
        end else if (wr_hit && off == 7'h40) begin
            mask_q <= (mask_q | reg_wdata) & IMPL_MASK;
        end else if (wr_hit && off == 7'h44) begin
            mask_q <= mask_q & ~reg_wdata;
        end
    end
    // ====
    // Assertions
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
        else $error("read data not zero outside a read answer");
    AST_FOREIGN_RD: assert property (reg_rd && !hit |=> reg_rdata_q == 32'h0)
        else $error("read outside the window returned data");
    AST_WO_RD: assert property (rd_hit && !ro_off |=> reg_rdata_q == 32'h0)
        else $error("write-only or reserved offset returned data");
    AST_UNIMPL: assert property ((reg_rdata_q & ~IMPL_MASK) == 32'h0)
        else $error("unimplemented line bit read as one");
    AST_OE_RESET: assert property ($rose(nrst) |=> (pin_oe_q & OWNER_RESET) == 32'h0)
        else $error("owned line driven right after reset");
    AST_OWNED_OFF: assert property ((wr_hit && off == 7'h00) ##1 !(wr_hit && off == 7'h04)
        |=> ((periph_in_q ^ OFF_LEVEL) & $past(reg_wdata, 2) & IMPL_MASK) == 32'h0)
        else $error("owned line leaks to peripheral input");
    AST_OUT_SET: assert property ((wr_hit && off == 7'h30) ##1 !(wr_hit && off == 7'h34)
        ##1 (rd_hit && off == 7'h38)
        |=> (reg_rdata_q & $past(reg_wdata, 3)) == ($past(reg_wdata, 3) & IMPL_MASK))
        else $error("output data bit not set");
    AST_ISR_CLEAR: assert property ($stable(pin_in) [*8] ##0 (rd_hit && off == 7'h4C)
        ##2 (rd_hit && off == 7'h4C) |=> reg_rdata_q == 32'h0)
        else $error("change status not cleared by read");
    AST_NO_MASK_IRQ: assert property (mask_q == 32'h0 |=> !irq_q)
        else $error("interrupt with empty mask");
    AST_MASK_RD: assert property ((rd_hit && off == 7'h48) |=> reg_rdata_q == $past(mask_q))
        else $error("mask read back wrong");
    CVR_IRQ: cover property ($rose(irq_q));
    CVR_ISR_RD: cover property (rd_hit && off == 7'h4C);
    CVR_DRIVE: cover property (pin_oe_q != 32'h0);
endmodule // pilc_ctrl_props

bind pilc_ctrl pilc_ctrl_props #(.BASE_ADDR(BASE_ADDR), .OWNER_RESET(OWNER_RESET),
    .IMPL_MASK(IMPL_MASK), .OFF_LEVEL(OFF_LEVEL)) pilc_ctrl_props_inst (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .pin_in(pin_in),
    .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_in_q(periph_in_q), .irq_q(irq_q));

// >>> pilc_defines.vh
// Constants shared by the parallel I/O line controller files.
`ifndef PILC_DEFINES_VH
`define PILC_DEFINES_VH

// ============================================================
// Base addresses of the two controller instances
`define PILC_FIRST_INSTANCE_BASE 32'hFFFEC000
`define PILC_SECOND_INSTANCE_BASE 32'hFFFF0000

// ============================================================
// Register offsets within one instance
`define PILC_OFF_LINE_OWNER_SET 7'h00
`define PILC_OFF_LINE_OWNER_CLEAR 7'h04
`define PILC_OFF_LINE_OWNER_STATUS 7'h08
`define PILC_OFF_DRIVE_ENABLE_SET 7'h10
`define PILC_OFF_DRIVE_ENABLE_CLEAR 7'h14
`define PILC_OFF_DRIVE_ENABLE_STATUS 7'h18
`define PILC_OFF_GLITCH_FILTER_SET 7'h20
`define PILC_OFF_GLITCH_FILTER_CLEAR 7'h24
`define PILC_OFF_GLITCH_FILTER_STATUS 7'h28
`define PILC_OFF_OUT_LEVEL_SET 7'h30
`define PILC_OFF_OUT_LEVEL_CLEAR 7'h34
`define PILC_OFF_OUT_LEVEL_STATUS 7'h38
`define PILC_OFF_PIN_LEVEL_SAMPLE 7'h3C
`define PILC_OFF_CHANGE_IRQ_ENABLE 7'h40
`define PILC_OFF_CHANGE_IRQ_DISABLE 7'h44
`define PILC_OFF_CHANGE_IRQ_MASK 7'h48
`define PILC_OFF_CHANGE_IRQ_STATUS 7'h4C
`define PILC_OFF_OPEN_DRAIN_SET 7'h50
`define PILC_OFF_OPEN_DRAIN_CLEAR 7'h54
`define PILC_OFF_OPEN_DRAIN_STATUS 7'h58

// ============================================================
// Address window: offsets occupy the low seven address bits
`define PILC_OFF_BITS 7

// ============================================================
// Reset values
`define PILC_OWNER_RST_FIRST 32'h3DFFFFFF
`define PILC_OWNER_RST_SECOND 32'h00FFFFC0
`define PILC_CFG_RST 32'h00000000

// ============================================================
// Implemented lines per instance
`define PILC_IMPL_FIRST 32'h3FFFFFFF
`define PILC_IMPL_SECOND 32'h00FFFFFF

// ============================================================
// Peripheral input level while the controller owns a line
`define PILC_OFF_LEVEL_DEFAULT 32'h00000000

// ============================================================
// Cycles until the pin pipeline holds real pin levels after reset
`define PILC_PRIME_CYCLES 3'h4

`endif

// >>> pilc_glitch_filter.v
// Per-line input glitch filter for the parallel I/O line controller.
`timescale 1ns/100ps
module pilc_glitch_filter #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input wire clock,
    input wire nrst,
    // Lines
    input wire [WIDTH-1:0] level_in,
    input wire [WIDTH-1:0] filter_en,
    output reg [WIDTH-1:0] level_q
);

    reg [WIDTH-1:0] hist_q;
    wire [WIDTH-1:0] agree;
    wire [WIDTH-1:0] level_d;

    // A filtered line only follows the input once two successive samples agree,
    // so a pulse of a single clock period never reaches the change detector.
    assign agree = ~(level_in ^ hist_q);
    assign level_d = (~filter_en & level_in) | (filter_en & agree & level_in)
                   | (filter_en & ~agree & level_q);

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hist_q <= {WIDTH{1'b0}};
            level_q <= {WIDTH{1'b0}};
        end else begin
            hist_q <= level_in;
            level_q <= level_d;
        end
    end

endmodule // pilc_glitch_filter

// >>> pilc_pin_model.sv
// Pin model: outside drivers, with no pull-up, behind the controller pads.
`timescale 1ns/100ps
module pilc_pin_model (
    // Pad side of the controller
    input wire [31:0] pin_out_q,
    input wire [31:0] pin_oe_q,
    // Level the outside world puts on released pins
    input wire [31:0] ext_level,
    output wire [31:0] pin_in
);
    // A released line shows the outside level, never the last driven value.
    assign pin_in = (pin_oe_q & pin_out_q) | (~pin_oe_q & ext_level);
endmodule // pilc_pin_model
